// ---- spm_port.sv ----
// serial port of the controller: master or slave, registers on the system bus
//
// Behaviour
// (R1) one byte each way, msb first
// (R2) miso input as master, output as slave
// (R3) mosi output as master, input as slave
// (R4) one bit per clock period, eight periods
// (R5) master bit drives clock, else clock input
// (R6) launch on one edge, sample the other
// (R7) both ends share polarity and phase
// (R8) slave moves data only while select low
// (R9) phase 0 partner toggles select per byte
// (R10) slave mode: rate bit 0 reads select
// (R11) done flag at byte end, cleared write/read
// (R12) collision flag on busy data write
// (R13) enable bit hands pins to serial port
// (R14) polarity bit sets clock idle level
// (R15) phase bit: leading edge launches data
// (R16) master rate core clock /2,/4,/8,/16
// (R17) control register resets to 04h
// (R18) master write starts; slave follows clock
module spm_port (
	input  wire logic        clock,      // core clock, 25 MHz
	input  wire logic        rstn,       // async reset, low
	input  wire logic        hsel,       // slave select
	input  wire logic [31:0] haddr,      // byte address
	input  wire logic [1:0]  htrans,     // transfer type
	input  wire logic        hwrite,     // write when high
	input  wire logic [2:0]  hsize,      // word only
	input  wire logic [31:0] hwdata,     // write data
	input  wire logic        hready,     // bus ready in
	output logic             hreadyout,  // always ready
	output logic [31:0]      hrdata,     // read data
	output logic             hresp,      // always okay
	output logic             spi_pins_sel, // pins serve this port
	spm_if.dev               link        // serial pins
);
	import spm_pkg::*;

	logic [7:0]  ctrl_r;
	logic [7:0]  tx_r;
	logic        wr_ctrl_r;
	logic        wr_data_r;
	logic [SPM_DIV_W-1:0] div_r;
	spm_mst_e    mst_r;
	logic        sclk_r;
	logic        sclk_prev_r;
	logic        sclk_oe_r;
	logic        mosi_oe_r;
	logic        miso_oe_r;
	logic        sout;
	logic [7:0]  rx_w;
	logic [2:0]  cnt_w;
	logic        done_w;

	// ----------------------------------------
	// control field decode
	// ----------------------------------------
	wire en_w     = ctrl_r[SPM_SEL_BIT];
	wire master_w = ctrl_r[SPM_MST_BIT];
	wire clock_idle_level_bit_w   = ctrl_r[SPM_POL_BIT];
	wire clock_edge_phase_bit_w   = ctrl_r[SPM_PHA_BIT];
	wire slave_w  = en_w & ~master_w;
	wire sel_w    = slave_w & ~link.ss_n;  // (R8)

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire take_w    = hsel & hready & htrans[1];
	wire a_ctrl_w  = (haddr == SPM_CTRL_OFS);
	wire a_data_w  = (haddr == SPM_DATA_OFS);
	wire rd_data_w = take_w & ~hwrite & a_data_w;
	wire [7:0] ctrl_rd_w = {ctrl_r[7:1], master_w ? ctrl_r[SPM_RLO_BIT] : link.ss_n};  // (R10)
	wire [7:0] din_w = wr_data_r ? hwdata[7:0] : tx_r;

	// ----------------------------------------
	// busy and serial edges
	// ----------------------------------------
	wire m_run_w   = (mst_r != SPM_IDLE);
	wire s_busy_w  = sel_w & ((cnt_w != 3'h0) | (link.serial_clock_pin != clock_idle_level_bit_w));
	wire busy_w    = m_run_w | s_busy_w;
	wire start_w   = wr_data_r & ~busy_w & en_w & master_w;  // (R18)
	wire tick_w    = m_run_w & (div_r == spm_half_lim(ctrl_r[1:0]));  // (R16)
	wire m_lead_w  = tick_w & (sclk_r == clock_idle_level_bit_w);  // (R14)
	wire m_trail_w = tick_w & (sclk_r != clock_idle_level_bit_w);
	wire m_last_w  = (clock_edge_phase_bit_w ? m_trail_w : m_lead_w) & (cnt_w == 3'h7);  // (R4)
	wire s_edge_w  = sel_w & (link.serial_clock_pin != sclk_prev_r);  // (R7)
	wire s_lead_w  = s_edge_w & (sclk_prev_r == clock_idle_level_bit_w);
	wire s_trail_w = s_edge_w & (sclk_prev_r != clock_idle_level_bit_w);
	wire load_w    = start_w | (slave_w & (link.ss_n | (wr_data_r & ~busy_w)));
	wire lead_w    = master_w ? m_lead_w : s_lead_w;
	wire trail_w   = master_w ? m_trail_w : s_trail_w;
	wire sin_w     = master_w ? link.miso : link.mosi;  // (R2)

	spm_shift #(
		.W (SPM_BYTE_W)
	) u_shift (
		.clock (clock),
		.rstn  (rstn),
		.load  (load_w),
		.din   (din_w),
		.lead  (lead_w),
		.trail (trail_w),
		.clock_edge_phase_bit  (clock_edge_phase_bit_w),
		.sin   (sin_w),
		.sout  (sout),
		.rx    (rx_w),
		.cnt   (cnt_w),
		.done  (done_w)
	);

	// ----------------------------------------
	// bus slave: zero wait, read data registered in address phase
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_ctrl_r <= 1'b0;
			wr_data_r <= 1'b0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_ctrl_r <= take_w & hwrite & a_ctrl_w;
			wr_data_r <= take_w & hwrite & a_data_w;
			if (take_w & ~hwrite) begin
				hrdata <= a_ctrl_w ? {24'h00_0000, ctrl_rd_w} :
					(a_data_w ? {24'h00_0000, rx_w} : 32'h0000_0000);
			end
		end
	end

	// control and data registers; hardware sets win over clears
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= SPM_CTRL_RST;  // (R17)
			tx_r   <= SPM_DATA_RST;
		end else begin
			if (wr_ctrl_r) begin
				ctrl_r <= hwdata[7:0];  // (R11)
			end
			if (rd_data_w) begin
				ctrl_r[SPM_DONE_BIT] <= 1'b0;  // (R11)
			end
			if (wr_data_r & ~busy_w) begin
				tx_r <= hwdata[7:0];
			end
			if (wr_data_r & busy_w) begin
				ctrl_r[SPM_WRITE_COLLISION_FLAG_BIT] <= 1'b1;  // (R12)
			end
			if (done_w) begin
				ctrl_r[SPM_DONE_BIT] <= 1'b1;  // (R11)
			end
		end
	end

	// ----------------------------------------
	// master sequencer and clock divider
	// ----------------------------------------
	// phase 0 needs one extra trailing edge after the last sample;
	// leave run on the last sample itself, a late done would add edges at /2
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mst_r  <= SPM_IDLE;
			div_r  <= '0;
			sclk_r <= 1'b0;
		end else begin
			div_r <= (tick_w | ~m_run_w) ? '0 : div_r + 1'b1;
			case (mst_r)
				SPM_IDLE: begin
					sclk_r <= clock_idle_level_bit_w;  // (R14)
					if (start_w) begin
						mst_r <= SPM_RUN;  // (R18)
					end
				end
				SPM_RUN: begin
					if (tick_w) begin
						sclk_r <= ~sclk_r;
					end
					if (m_last_w) begin
						mst_r <= clock_edge_phase_bit_w ? SPM_IDLE : SPM_TAIL;
					end
				end
				SPM_TAIL: begin
					if (tick_w) begin
						sclk_r <= ~sclk_r;
						mst_r  <= SPM_IDLE;
					end
				end
				default: begin
					mst_r <= SPM_IDLE;
				end
			endcase
			if (~(en_w & master_w)) begin
				mst_r <= SPM_IDLE;
			end
		end
	end

	// ----------------------------------------
	// pin direction, registered so every output is a flop
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_r <= 1'b0;
			sclk_oe_r   <= 1'b0;
			mosi_oe_r   <= 1'b0;
			miso_oe_r   <= 1'b0;
		end else begin
			sclk_prev_r <= link.serial_clock_pin;
			sclk_oe_r   <= en_w & master_w;  // (R5)
			mosi_oe_r   <= en_w & master_w;  // (R3)
			miso_oe_r   <= sel_w;            // (R2)
		end
	end

	assign spi_pins_sel     = ctrl_r[SPM_SEL_BIT];  // (R13)
	assign link.dev_sclk_o  = sclk_r;
	assign link.dev_sclk_oe = sclk_oe_r;
	assign link.dev_mosi_o  = sout;  // (R1)
	assign link.dev_mosi_oe = mosi_oe_r;
	assign link.dev_miso_o  = sout;
	assign link.dev_miso_oe = miso_oe_r;
endmodule

// ---- spm_pkg.sv ----
// shared constants and types for the serial port and its partner
package spm_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [31:0] SPM_CTRL_OFS  = 32'h0000_00F8;
	localparam logic [31:0] SPM_DATA_OFS  = 32'h0000_00FC;
	localparam logic [7:0]  SPM_CTRL_RST  = 8'h04;
	localparam logic [7:0]  SPM_DATA_RST  = 8'h00;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int SPM_DONE_BIT = 7;
	localparam int SPM_WRITE_COLLISION_FLAG_BIT = 6;
	localparam int SPM_SEL_BIT  = 5;
	localparam int SPM_MST_BIT  = 4;
	localparam int SPM_POL_BIT  = 3;
	localparam int SPM_PHA_BIT  = 2;
	localparam int SPM_RHI_BIT  = 1;
	localparam int SPM_RLO_BIT  = 0;

	// ----------------------------------------
	// widths and timing
	// ----------------------------------------
	localparam int SPM_BYTE_W   = 8;
	localparam int SPM_DIV_W    = 4;
	localparam int SPM_PEER_HALF = 4;

	typedef enum logic [1:0] {
		SPM_IDLE = 2'b00,
		SPM_RUN  = 2'b01,
		SPM_TAIL = 2'b10
	} spm_mst_e;

	// half period of the serial clock in core cycles, minus one
	function automatic logic [SPM_DIV_W-1:0] spm_half_lim(input logic [1:0] code);
		logic [SPM_DIV_W-1:0] one;
		one = {{(SPM_DIV_W-1){1'b0}}, 1'b1};
		spm_half_lim = (one << code) - one;
	endfunction

endpackage

// ---- spm_if.sv ----
// serial link pins between the port and its partner, with wire resolution
interface spm_if;
	logic dev_sclk_o;
	logic dev_sclk_oe;
	logic dev_mosi_o;
	logic dev_mosi_oe;
	logic dev_miso_o;
	logic dev_miso_oe;
	logic peer_sclk_o;
	logic peer_sclk_oe;
	logic peer_mosi_o;
	logic peer_mosi_oe;
	logic peer_miso_o;
	logic peer_miso_oe;
	logic peer_ss_n_o;
	logic peer_ss_n_oe;
	logic serial_clock_pin;
	logic mosi;
	logic miso;
	logic ss_n;

	// ----------------------------------------
	// resolved wire levels, undriven pins pulled high
	// ----------------------------------------
	assign serial_clock_pin = dev_sclk_oe ? dev_sclk_o : (peer_sclk_oe ? peer_sclk_o : 1'b1);
	assign mosi = dev_mosi_oe ? dev_mosi_o : (peer_mosi_oe ? peer_mosi_o : 1'b1);
	assign miso = dev_miso_oe ? dev_miso_o : (peer_miso_oe ? peer_miso_o : 1'b1);
	assign ss_n = peer_ss_n_oe ? peer_ss_n_o : 1'b1;

	modport dev (
		output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
		input  serial_clock_pin, mosi, miso, ss_n
	);
	modport peer (
		output peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe,
		output peer_miso_o, peer_miso_oe, peer_ss_n_o, peer_ss_n_oe,
		input  serial_clock_pin, mosi, miso, ss_n
	);
endinterface

// ---- spm_shift.sv ----
// byte shift engine: samples on one edge, launches on the other
module spm_shift #(
	parameter int W = spm_pkg::SPM_BYTE_W
) (
	input  wire logic                 clock,  // core clock
	input  wire logic                 rstn,   // async reset, low
	input  wire logic                 load,   // preload shifter from din
	input  wire logic [W-1:0]         din,    // byte to send
	input  wire logic                 lead,   // leading serial edge
	input  wire logic                 trail,  // trailing serial edge
	input  wire logic                 clock_edge_phase_bit,   // phase select
	input  wire logic                 sin,    // serial data in
	output logic                      sout,   // serial data out
	output logic [W-1:0]              rx,     // last byte received
	output logic [$clog2(W)-1:0]      cnt,    // bits sampled so far
	output logic                      done    // one-cycle end of byte
);
	import spm_pkg::*;

	localparam int CW = $clog2(W);

	logic [W-1:0] sh_r;
	wire          samp_e = clock_edge_phase_bit ? trail : lead;  // (R6)
	wire          laun_e = clock_edge_phase_bit ? lead : trail;  // (R15)
	wire          last_w = (cnt == CW'(W - 1));
	wire [W-1:0]  shin_w = {sh_r[W-2:0], sin};

	// msb leaves first, one bit in and one out per clock period
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sh_r <= '0;
			sout <= 1'b0;
			rx   <= '0;
			cnt  <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				sh_r <= din;
				sout <= din[W-1];  // (R1)
				cnt  <= '0;
			end else if (samp_e) begin
				cnt  <= cnt + 1'b1;  // (R4)
				sh_r <= last_w ? din : shin_w;
				if (last_w) begin
					rx   <= shin_w;
					done <= 1'b1;
				end
			end else if (laun_e) begin
				sout <= sh_r[W-1];  // (R6)
			end
		end
	end
endmodule

// ---- spm_peer.sv ----
// partner end of the serial link: plain master or slave logic
module spm_peer #(
	parameter int HALF = spm_pkg::SPM_PEER_HALF
) (
	input  wire logic        clock,     // core clock
	input  wire logic        rstn,      // async reset, low
	input  wire logic        is_master, // act as master
	input  wire logic        clock_idle_level_bit,      // clock idle level
	input  wire logic        clock_edge_phase_bit,      // phase select
	input  wire logic        start,     // pulse: send tx_byte
	input  wire logic [7:0]  tx_byte,   // byte to send
	output logic [7:0]       rx_byte,   // last byte received
	output logic             done,      // pulse: byte finished
	output logic             busy,      // master transfer running
	spm_if.peer              link       // serial pins
);
	import spm_pkg::*;

	spm_mst_e  st_r;
	logic [7:0] div_r;
	logic       sclk_r;
	logic       prev_r;
	logic       sout;
	logic [2:0] cnt_w;
	logic       arm_r;
	logic       fin_r;

	// ----------------------------------------
	// edges as master (own divider) or slave (pin)
	// ----------------------------------------
	wire run_w   = (st_r != SPM_IDLE);
	wire tick_w  = run_w & (div_r == 8'(HALF - 1));
	wire sel_w   = ~is_master & ~link.ss_n;
	// as slave, select is released once the byte is done and the clock idles
	wire rel_w   = arm_r & (done | fin_r) & (link.serial_clock_pin == clock_idle_level_bit);  // (R9)
	wire s_edge  = sel_w & (link.serial_clock_pin != prev_r);
	wire lead_w  = is_master ? (tick_w & (sclk_r == clock_idle_level_bit)) : (s_edge & (prev_r == clock_idle_level_bit));
	wire trail_w = is_master ? (tick_w & (sclk_r != clock_idle_level_bit)) : (s_edge & (prev_r != clock_idle_level_bit));
	wire load_w  = is_master ? (start & ~run_w) : link.ss_n;

	spm_shift #(
		.W (SPM_BYTE_W)
	) u_shift (
		.clock (clock),
		.rstn  (rstn),
		.load  (load_w),
		.din   (tx_byte),
		.lead  (lead_w),
		.trail (trail_w),
		.clock_edge_phase_bit  (clock_edge_phase_bit),
		.sin   (is_master ? link.miso : link.mosi),
		.sout  (sout),
		.rx    (rx_byte),
		.cnt   (cnt_w),
		.done  (done)
	);

	// master sequencer; select held low for the whole byte
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r   <= SPM_IDLE;
			div_r  <= 8'h00;
			sclk_r <= 1'b0;
			prev_r <= 1'b0;
			arm_r  <= 1'b0;
			fin_r  <= 1'b0;
		end else begin
			prev_r <= link.serial_clock_pin;
			arm_r  <= ~is_master & (arm_r ? ~rel_w : start);  // (R9)
			fin_r  <= arm_r & ~rel_w & (fin_r | done);
			div_r  <= (tick_w | ~run_w) ? 8'h00 : div_r + 8'h01;
			case (st_r)
				SPM_IDLE: begin
					sclk_r <= clock_idle_level_bit;
					if (is_master & start) begin
						st_r <= SPM_RUN;
					end
				end
				SPM_RUN: begin
					if (tick_w) begin
						sclk_r <= ~sclk_r;
					end
					if (done) begin
						st_r <= clock_edge_phase_bit ? SPM_IDLE : SPM_TAIL;  // (R9)
					end
				end
				SPM_TAIL: begin
					if (tick_w) begin
						sclk_r <= ~sclk_r;
						st_r   <= SPM_IDLE;
					end
				end
				default: begin
					st_r <= SPM_IDLE;
				end
			endcase
		end
	end

	assign busy              = run_w;
	assign link.peer_sclk_o  = sclk_r;
	assign link.peer_sclk_oe = is_master;
	assign link.peer_mosi_o  = sout;
	assign link.peer_mosi_oe = is_master;
	assign link.peer_miso_o  = sout;
	assign link.peer_miso_oe = sel_w;
	// as slave, start stands in for the master's select line for one byte
	assign link.peer_ss_n_o  = is_master ? ~run_w : ~arm_r;  // (R9)
	assign link.peer_ss_n_oe = is_master | arm_r;
endmodule

// ---- spm_link_props.sv ----
// link-side assertions for the serial port facing its partner
module spm_link_props (
	input wire logic clock,            // core clock
	input wire logic rstn,             // async reset, low
	input wire logic clock_idle_level_bit,             // configured idle level
	input wire logic clock_edge_phase_bit,             // configured phase
	input wire logic dev_sclk_oe,      // port drives clock
	input wire logic dev_mosi_oe,      // port drives mosi
	input wire logic dev_miso_oe,      // port drives miso
	input wire logic peer_ss_n_oe,     // partner drives select
	input wire logic peer_sclk_oe,     // partner drives clock
	input wire logic serial_clock_pin, // resolved clock
	input wire logic mosi,             // resolved mosi
	input wire logic miso,             // resolved miso
	input wire logic ss_n              // resolved select
);
	logic       sclk_q_r;
	logic       ss_q_r;
	logic       oe_q_r;
	logic [4:0] still_r;
	logic [4:0] edges_r;

	// ----------------------------------------
	// edge and frame decoding
	// ----------------------------------------
	wire sclk_chg   = serial_clock_pin != sclk_q_r;
	wire lead_edge  = sclk_chg && (sclk_q_r == clock_idle_level_bit);
	wire samp_edge  = sclk_chg && (lead_edge != clock_edge_phase_bit);
	wire peer_frame = !ss_n && !ss_q_r;
	wire dev_frame  = dev_sclk_oe && oe_q_r;

	// history, quiet-time and per-frame edge count; oe rise excluded since pin leaves pull-up
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sclk_q_r <= 1'b1;
			ss_q_r <= 1'b1;
			oe_q_r <= 1'b0;
			still_r <= 5'h00;
			edges_r <= 5'h00;
		end else begin
			sclk_q_r <= serial_clock_pin;
			ss_q_r <= ss_n;
			oe_q_r <= dev_sclk_oe;
			still_r <= sclk_chg ? 5'h00 : (still_r == 5'h1F ? still_r : still_r + 5'h01);
			edges_r <= (ss_n && ss_q_r) ? 5'h00 : edges_r + {4'h0, sclk_chg};
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	pin_excl_a: assert property (dev_mosi_oe |-> !dev_miso_oe)
		else $error("port drives mosi and miso together");
	master_drive_a: assert property (dev_sclk_oe |-> dev_mosi_oe)
		else $error("master clock without mosi drive");
	slave_clock_a: assert property (peer_sclk_oe && !ss_n |-> !dev_sclk_oe && !dev_mosi_oe)
		else $error("port drives clock or mosi while selected");
	mosi_hold_a: assert property ((dev_frame || peer_frame) && samp_edge |-> $stable(mosi))
		else $error("mosi moved on sampling edge");
	miso_hold_a: assert property (peer_frame && samp_edge |-> $stable(miso))
		else $error("miso moved on sampling edge");
	idle_level_a: assert property (dev_frame && still_r == 5'd20 |-> serial_clock_pin == clock_idle_level_bit)
		else $error("master clock idles at wrong level");
	edge_count_a: assert property ($rose(ss_n) |=> edges_r == 5'd16)
		else $error("frame did not carry sixteen clock edges");
	slave_out_a: assert property ((peer_sclk_oe && !ss_n) [*4] |-> dev_miso_oe)
		else $error("selected slave does not drive miso");
endmodule

// ---- spm_port_tb.sv ----
// self-checking bench: serial port against its partner over one link
`define SPM_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module spm_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spm_pkg::*;

	logic        clock, rstn, hsel, hwrite, hready, hreadyout, hresp, spi_pins_sel;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        is_master, clock_idle_level_bit, clock_edge_phase_bit, start, pdone, sq;
	logic [7:0]  tx_byte, rx_byte;
	logic [3:0]  gap, hp;
	logic [4:0]  edges;
	int          mismatches, samples_checked, cycles;

	spm_if lnk ();
	assign hready = hreadyout;

	spm_port i_spm_port (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.spi_pins_sel(spi_pins_sel), .link(lnk));
	spm_peer i_spm_peer (.clock(clock), .rstn(rstn), .is_master(is_master), .clock_idle_level_bit(clock_idle_level_bit),
		.clock_edge_phase_bit(clock_edge_phase_bit), .start(start), .tx_byte(tx_byte), .rx_byte(rx_byte), .done(pdone),
		.busy(), .link(lnk));
	spm_link_props i_spm_link_props (.clock(clock), .rstn(rstn), .clock_idle_level_bit(clock_idle_level_bit), .clock_edge_phase_bit(clock_edge_phase_bit),
		.dev_sclk_oe(lnk.dev_sclk_oe), .dev_mosi_oe(lnk.dev_mosi_oe),
		.dev_miso_oe(lnk.dev_miso_oe), .peer_ss_n_oe(lnk.peer_ss_n_oe),
		.peer_sclk_oe(lnk.peer_sclk_oe),
		.serial_clock_pin(lnk.serial_clock_pin), .mosi(lnk.mosi), .miso(lnk.miso),
		.ss_n(lnk.ss_n));

	// ----------------------------------------
	// clock, hang guard, clock-pin monitor
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ceiling well above the longest expected run
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	// half period and edge count of the serial clock; only this process writes them
	always @(posedge clock) begin
		if (!rstn) begin
			sq <= 1'b1;
			gap <= 4'h0;
			hp <= 4'h0;
			edges <= 5'h00;
		end else begin
			if (lnk.serial_clock_pin != sq) begin
				hp <= gap;
				gap <= 4'h1;
				edges <= edges + 5'h01;
			end else if (gap != 4'hF) begin
				gap <= gap + 4'h1;
			end
			sq <= lnk.serial_clock_pin;
		end
	end

	// ----------------------------------------
	// bus tasks and verdict
	// ----------------------------------------
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] v;
		logic [7:0]  d, cfg;
		logic [1:0]  rate;
		int          k;
		logic [4:0]  e0;
		{rstn, hsel, hwrite, is_master, clock_idle_level_bit, clock_edge_phase_bit, start} = 7'h00;
		{haddr, hwdata, htrans, hsize, tx_byte} = '0;
		void'($urandom(58327));
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		bus(1'b0, SPM_CTRL_OFS, 32'h0, v);
		// master bit is clear after reset, so bit 0 shows the pulled-up select
		`SPM_CHK(v, {24'h0, SPM_CTRL_RST[7:1], 1'b1})
		`SPM_CHK({hreadyout, hresp}, 2'b10)
		`SPM_CHK({spi_pins_sel, lnk.dev_sclk_oe, lnk.dev_mosi_oe, lnk.dev_miso_oe}, 4'h0)
		bus(1'b0, 32'h0000_00F4, 32'h0, v);
		`SPM_CHK(v, 32'h0)
		// port as master over every rate and mode, partner as slave
		for (int m = 0; m < 16; m++) begin
			rate = 2'(m >> 2);
			cfg = {4'h1, m[1], m[0], rate};
			bus(1'b1, SPM_CTRL_OFS, {24'h0, cfg}, v);
			{clock_idle_level_bit, clock_edge_phase_bit} <= 2'(m);
			is_master <= 1'b0;
			tx_byte <= 8'($urandom);
			d = 8'($urandom);
			bus(1'b1, SPM_CTRL_OFS, {24'h0, cfg | 8'h20}, v);
			repeat (20) @(posedge clock);
			`SPM_CHK({spi_pins_sel, lnk.dev_sclk_oe, lnk.dev_mosi_oe, lnk.dev_miso_oe}, 4'hE)
			// arm the partner slave; it cannot follow the /2 rate, so not there
			if (rate != 2'd0) begin
				start <= 1'b1;
				@(posedge clock);
				start <= 1'b0;
			end
			e0 = edges;
			bus(1'b1, SPM_DATA_OFS, {24'h0, d}, v);
			bus(1'b1, SPM_DATA_OFS, {24'h0, ~d}, v);
			k = 0;
			do begin
				bus(1'b0, SPM_CTRL_OFS, 32'h0, v);
				k++;
			end while (v[SPM_DONE_BIT] !== 1'b1 && k < 200);
			repeat (20) @(posedge clock);
			`SPM_CHK(v[7:0], cfg | 8'hE0)
			`SPM_CHK(5'(edges - e0), 5'd16)
			`SPM_CHK(hp, 4'd1 << rate)
			if (rate != 2'd0) `SPM_CHK(rx_byte, d)
			bus(1'b0, SPM_DATA_OFS, 32'h0, v);
			if (rate > 2'd1) `SPM_CHK(v[7:0], tx_byte)
			bus(1'b0, SPM_CTRL_OFS, 32'h0, v);
			`SPM_CHK(v[7:0], cfg | 8'h60)
		end
		// port as slave in every mode, partner as master
		for (int m = 0; m < 4; m++) begin
			cfg = {4'h0, m[1], m[0], 2'b00};
			bus(1'b1, SPM_CTRL_OFS, {24'h0, cfg}, v);
			{clock_idle_level_bit, clock_edge_phase_bit} <= 2'(m);
			is_master <= 1'b1;
			bus(1'b1, SPM_CTRL_OFS, {24'h0, cfg | 8'h20}, v);
			d = 8'($urandom);
			bus(1'b1, SPM_DATA_OFS, {24'h0, d}, v);
			bus(1'b0, SPM_CTRL_OFS, 32'h0, v);
			`SPM_CHK(v[7:0], cfg | 8'h21)
			tx_byte <= 8'($urandom);
			start <= 1'b1;
			@(posedge clock);
			start <= 1'b0;
			bus(1'b0, SPM_CTRL_OFS, 32'h0, v);
			`SPM_CHK(v[SPM_RLO_BIT], 1'b0)
			k = 0;
			while (pdone !== 1'b1 && k < 300) begin
				@(posedge clock);
				k++;
			end
			`SPM_CHK(rx_byte, d)
			repeat (10) @(posedge clock);
			bus(1'b0, SPM_CTRL_OFS, 32'h0, v);
			`SPM_CHK(v[7:0], cfg | 8'hA1)
			bus(1'b0, SPM_DATA_OFS, 32'h0, v);
			`SPM_CHK(v[7:0], tx_byte)
		end
		end_of_test();
	end
endmodule
